// ==== bench/prsc_host.sv ====
// Host model that drives the register strobes of the control block
`timescale 1ns/10ps
module prsc_host (
  input  wire logic       ref_clk,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // Quiet bus until the first transfer
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // One-cycle write; idle lines flip so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~v;
  endtask
  // Read data stands for one cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    reg_addr  <= ~a;
    #1 v = reg_rdata;
  endtask
endmodule

// ==== bench/tb.sv ====
// Self-checking bench for the page, restart, sleep and shutdown block
`timescale 1ns/10ps
module tb;
  import prsc_pkg::*;
  // Short tick keeps the long charge and keepalive times quick
  localparam int TC = 4;
  logic       ref_clk;
  logic       rst_n;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] page_sel;
  logic       pin_n;
  logic [1:0] addr_pins;
  logic       done;
  logic [6:0] target_addr;
  logic       supply_sel;
  logic       sleep_active;
  logic       ref_busy;
  logic       incap_busy;
  logic       reg_on;
  logic [7:0] sfmt;
  logic [7:0] d;
  int         n_mismatch;
  int         checked;
  int         cyc;
  int         rt[4] = '{7, 20, 100, 200};
  int         it[4] = '{5, 25, 50, 100};
  int         ka[4] = '{60, 50, 20, 10};
  // ==========================================================
  // Instances
  prsc_ctrl #(.TICK_CYCLES(TC)) prsc_ctrl_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_wr_en(wr_en),
    .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .page_sel(page_sel), .shutdown_pin_n(pin_n),
    .addr_pins(addr_pins), .shutdown_done(done),
    .target_addr(target_addr), .analog_supply_source_sel(supply_sel),
    .sleep_active(sleep_active), .ref_charge_busy(ref_busy),
    .incap_charge_busy(incap_busy), .digital_regulator_on(reg_on),
    .serial_format(sfmt));
  prsc_host prsc_host_i (
    .ref_clk(ref_clk), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata));
  // ==========================================================
  // Checking helpers
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Tick phase and synchronisers blur counts by a few cycles
  function automatic logic [7:0] inr(int n, int e, int lo, int hi);
    return 8'(n >= e - lo && n <= e + hi);
  endfunction
  // Counts cycles a busy or enable output stays high
  task automatic meas(input int sel, output int n);
    logic b;
    n = 0;
    for (int i = 0; i < 1200; i++) begin
      // Edge-time read sees the settled value of the cycle before
      @(posedge ref_clk);
      b = (sel == 0) ? ref_busy : (sel == 1) ? incap_busy : reg_on;
      if (b === 1'b1) n++;
      else if (n > 0 || sel == 2) break;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    prsc_host_i.rd(8'h00, d); chk(d, 8'h00);
    prsc_host_i.rd(8'h01, d); chk(d, 8'h00);
    prsc_host_i.rd(8'h02, d); chk(d, 8'h00);
    prsc_host_i.rd(8'h05, d); chk(d, 8'h05);
    chk(8'(sleep_active), 8'h01);
    chk(8'(target_addr), 8'h4e);
    chk(8'(reg_on), 8'h01);
    chk(sfmt, 8'h30);
  endtask
  // Other pages hide the page-zero registers
  task automatic t_page();
    prsc_host_i.wr(8'h00, 8'hff);
    @(posedge ref_clk);
    chk(page_sel, 8'hff);
    prsc_host_i.rd(8'h05, d); chk(d, 8'h00);
    prsc_host_i.wr(8'h05, 8'h00);
    prsc_host_i.wr(8'h00, 8'h00);
    prsc_host_i.rd(8'h05, d); chk(d, 8'h05);
  endtask
  task automatic t_sleep();
    logic [1:0] c;
    int         nr;
    int         ni;
    for (int k = 0; k < 4; k++) begin
      c = 2'(k);
      prsc_host_i.wr(8'h02, 8'h00);
      prsc_host_i.wr(8'h05, {2'h0, c, 4'h5});
      prsc_host_i.wr(8'h02, {1'b1, 2'h0, c, 3'h7});
      fork
        meas(0, nr);
        meas(1, ni);
      join
      chk(inr(nr, rt[k] * TC, 6, 6), 8'h01);
      chk(inr(ni, it[k] * TC, 6, 6), 8'h01);
      chk(8'(sleep_active), 8'h00);
      chk(8'(supply_sel), 8'h01);
      chk(8'(target_addr), 8'h4c);
      prsc_host_i.rd(8'h02, d); chk(d, {1'b1, 2'h0, c, 3'h5});
    end
    prsc_host_i.wr(8'h02, 8'h00);
    repeat (3) @(posedge ref_clk);
    #1;
    chk(8'(sleep_active), 8'h01);
    chk(8'(supply_sel), 8'h00);
    chk(8'(target_addr), 8'h4e);
  endtask
  task automatic t_restart();
    prsc_host_i.wr(8'h02, 8'h85);
    prsc_host_i.wr(8'h07, 8'ha5);
    prsc_host_i.wr(8'h05, 8'h0b);
    prsc_host_i.rd(8'h07, d); chk(d, 8'ha5);
    prsc_host_i.wr(8'h01, 8'h01);
    prsc_host_i.rd(8'h01, d); chk(d, 8'h00);
    // Charge started by the wake above must be cut short
    chk(8'(ref_busy), 8'h00);
    prsc_host_i.rd(8'h02, d); chk(d, 8'h00);
    prsc_host_i.rd(8'h05, d); chk(d, 8'h05);
    prsc_host_i.rd(8'h07, d); chk(d, 8'h30);
    chk(8'(sleep_active), 8'h01);
    chk(8'(target_addr), 8'h4e);
    chk(sfmt, 8'h30);
  endtask
  task automatic t_shdn();
    int n;
    prsc_host_i.wr(8'h05, 8'h00);
    @(posedge ref_clk);
    pin_n <= 1'b0;
    meas(2, n);
    chk(inr(n, 4, 3, 2), 8'h01);
    for (int k = 0; k < 4; k++) begin
      pin_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk(8'(reg_on), 8'h01);
      prsc_host_i.wr(8'h05, 8'h04 | 8'(k));
      @(posedge ref_clk);
      pin_n <= 1'b0;
      meas(2, n);
      chk(inr(n, ka[k] * TC, 6, 10), 8'h01);
    end
    // Reserved policy code runs as the timed policy
    pin_n <= 1'b1;
    prsc_host_i.wr(8'h05, 8'h0f);
    repeat (6) @(posedge ref_clk);
    pin_n <= 1'b0;
    meas(2, n);
    chk(inr(n, ka[3] * TC, 6, 10), 8'h01);
    pin_n <= 1'b1;
    prsc_host_i.wr(8'h05, 8'h08);
    repeat (6) @(posedge ref_clk);
    pin_n <= 1'b0;
    repeat (300) @(posedge ref_clk);
    chk(8'(reg_on), 8'h01);
    done <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    chk(8'(reg_on), 8'h00);
    done <= 1'b0;
  endtask
  // ==========================================================
  // Clock, hang guard and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // A hang counts as a mismatch and ends the run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    rst_n = 1'b0;
    pin_n = 1'b1;
    addr_pins = 2'h2;
    done = 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_page();
    t_sleep();
    t_restart();
    t_shdn();
    tally_and_finish();
  end
endmodule

// ==== rtl/prsc_ctrl.sv ====
// Module: page, restart, sleep, supply and shutdown control registers
`timescale 1ns/10ps
module prsc_ctrl
  import prsc_pkg::*;
#(
  parameter int TICK_CYCLES = prsc_pkg::TICK_CYC
)
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic      [7:0] page_sel,
  input  wire logic       shutdown_pin_n,
  input  wire logic [1:0] addr_pins,
  input  wire logic       shutdown_done,
  output logic      [6:0] target_addr,
  output logic            analog_supply_source_sel,
  output logic            sleep_active,
  output logic            ref_charge_busy,
  output logic            incap_charge_busy,
  output logic            digital_regulator_on,
  output logic      [7:0] serial_format
);
  import prsc_pkg::*;

  typedef struct packed {
    logic [7:0]  page;
    logic        restart;
    logic [7:0]  sleep;
    logic [7:0]  shdn;
    logic [7:0]  sfmt;
    logic [7:0]  rdata;
    logic        exit_d;
    logic [1:0]  pin_s;
    logic [3:0]  apin_s;
    logic        pin_d;
    logic        asleep;
    logic        digital_regulator;
    logic [6:0]  taddr;
    logic [13:0] tick_cnt;
    logic        tick;
  } prsc_st_s;

  prsc_st_s    st_r;
  prsc_st_s    st_nxt;
  logic [1:0]  rsync_r;
  logic        rst_sync_n;
  logic        ka_busy;
  logic [7:0]  ref_ticks;
  logic [7:0]  incap_ticks;
  logic [7:0]  ka_ticks;
  logic        wake;
  logic        shut_fall;
  logic        page0;
  logic [1:0]  policy;

  // ==========================================================
  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsync_r <= 2'b00;
    end else begin
      rsync_r <= {rsync_r[0], 1'b1};
    end
  end
  assign rst_sync_n = rsync_r[1];

  // ==========================================================
  // Duration lookups
  always_comb begin
    case (st_r.sleep[PRSC_REFQ_LSB +: 2])
      2'h0:    ref_ticks = prsc_ticks(REFQ0_US);
      2'h1:    ref_ticks = prsc_ticks(REFQ1_US);
      2'h2:    ref_ticks = prsc_ticks(REFQ2_US);
      default: ref_ticks = prsc_ticks(REFQ3_US);
    endcase
    case (st_r.shdn[PRSC_INCAP_LSB +: 2])
      2'h0:    incap_ticks = prsc_ticks(INCAP0_US);
      2'h1:    incap_ticks = prsc_ticks(INCAP1_US);
      2'h2:    incap_ticks = prsc_ticks(INCAP2_US);
      default: incap_ticks = prsc_ticks(INCAP3_US);
    endcase
    case (st_r.shdn[PRSC_KA_LSB +: 2])
      2'h0:    ka_ticks = prsc_ticks(KA0_US);
      2'h1:    ka_ticks = prsc_ticks(KA1_US);
      2'h2:    ka_ticks = prsc_ticks(KA2_US);
      default: ka_ticks = prsc_ticks(KA3_US);
    endcase
  end

  assign policy    = st_r.shdn[PRSC_POLICY_LSB +: 2];
  assign page0     = (st_r.page == PRSC_PAGE_ZERO);
  // Wake edge starts both quick charges
  assign wake      = st_r.sleep[PRSC_EXIT_BIT] && !st_r.exit_d;
  // Pin falling edge, seen only after the synchroniser
  assign shut_fall = !st_r.pin_s[1] && st_r.pin_d;

  // ==========================================================
  // Next state: register file, tick base, regulator policy
  always_comb begin
    st_nxt          = st_r;
    st_nxt.pin_s    = {st_r.pin_s[0], shutdown_pin_n};
    st_nxt.apin_s   = {st_r.apin_s[1:0], addr_pins};
    st_nxt.pin_d    = st_r.pin_s[1];
    st_nxt.exit_d   = st_r.sleep[PRSC_EXIT_BIT];
    st_nxt.asleep   = !st_r.sleep[PRSC_EXIT_BIT];
    st_nxt.tick     = (st_r.tick_cnt == 14'(TICK_CYCLES - 1));
    st_nxt.tick_cnt = st_nxt.tick ? 14'h0000 : st_r.tick_cnt + 14'h0001;
    if (st_r.sleep[PRSC_BCAST_BIT]) begin
      st_nxt.taddr = PRSC_BCAST_ADDR;
    end else begin
      st_nxt.taddr = {PRSC_ADDR_BASE, st_r.apin_s[3:2]};
    end
    // Read data, registered; unmapped offsets read zero, other pages read only the page register
    st_nxt.rdata = 8'h00;
    if (reg_rd_en) begin
      if (reg_addr == PRSC_OFF_PAGE) begin
        st_nxt.rdata = st_r.page;
      end else if (page0) begin
        case (reg_addr)
          PRSC_OFF_RST:   st_nxt.rdata = {7'h00, st_r.restart};
          PRSC_OFF_SLEEP: st_nxt.rdata = st_r.sleep;
          PRSC_OFF_SHDN:  st_nxt.rdata = st_r.shdn;
          PRSC_OFF_SFMT:  st_nxt.rdata = st_r.sfmt;
          default:        st_nxt.rdata = 8'h00;
        endcase
      end
    end
    // Writes; page register exists on every page
    st_nxt.restart = 1'b0;
    if (reg_wr_en) begin
      if (reg_addr == PRSC_OFF_PAGE) begin
        st_nxt.page = reg_wdata;
      end else if (page0) begin
        case (reg_addr)
          PRSC_OFF_RST:   st_nxt.restart = reg_wdata[PRSC_RST_BIT];
          PRSC_OFF_SLEEP: st_nxt.sleep = reg_wdata & PRSC_SLEEP_WMASK;
          PRSC_OFF_SHDN:  st_nxt.shdn = reg_wdata & PRSC_SHDN_WMASK;
          PRSC_OFF_SFMT:  st_nxt.sfmt = reg_wdata;
          default:        st_nxt.sfmt = st_r.sfmt;
        endcase
      end
    end
    // Regulator: on while pin is high, policy decides after it falls
    if (st_r.pin_s[1]) begin
      st_nxt.digital_regulator      = 1'b1;
    end else begin
      if (shut_fall) begin
        // A finish in the fall cycle itself must not be lost
        st_nxt.digital_regulator = (policy != PRSC_POL_NOW) && !shutdown_done;
      end else begin
        case (policy)
          PRSC_POL_NOW:  st_nxt.digital_regulator = 1'b0;
          PRSC_POL_DONE: st_nxt.digital_regulator = st_r.digital_regulator && !shutdown_done;
          // Reserved code 3 behaves as the timed policy
          default: st_nxt.digital_regulator = st_r.digital_regulator && ka_busy && !shutdown_done;
        endcase
      end
    end
    // Restart pulse: page, sleep, shutdown and format registers back to defaults
    if (st_r.restart) begin
      st_nxt.page      = PRSC_RST_PAGE;
      st_nxt.sleep     = PRSC_RST_SLEEP;
      st_nxt.shdn      = PRSC_RST_SHDN;
      st_nxt.sfmt      = PRSC_RST_SFMT;
      st_nxt.restart   = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_r        <= '0;
      st_r.shdn   <= PRSC_RST_SHDN;
      st_r.sfmt   <= PRSC_RST_SFMT;
      st_r.pin_s  <= 2'b11;
      st_r.pin_d  <= 1'b1;
      st_r.digital_regulator   <= 1'b1;
      st_r.asleep <= 1'b1;
      st_r.taddr  <= {PRSC_ADDR_BASE, 2'b00};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Charge and keepalive timers
  prsc_timer u_ref (
    .clk   (ref_clk),
    .rst_n (rst_sync_n),
    .clr   (st_r.restart),
    .start (wake),
    .tick  (st_r.tick),
    .ticks (ref_ticks),
    .busy  (ref_charge_busy)
  );
  prsc_timer u_incap (
    .clk   (ref_clk),
    .rst_n (rst_sync_n),
    .clr   (st_r.restart),
    .start (wake),
    .tick  (st_r.tick),
    .ticks (incap_ticks),
    .busy  (incap_charge_busy)
  );
  prsc_timer u_ka (
    .clk   (ref_clk),
    .rst_n (rst_sync_n),
    .clr   (st_r.pin_s[1]),
    .start (shut_fall),
    .tick  (st_r.tick),
    .ticks (ka_ticks),
    .busy  (ka_busy)
  );

  // ==========================================================
  // Outputs straight from flops
  assign reg_rdata                = st_r.rdata;
  assign page_sel                 = st_r.page;
  assign target_addr              = st_r.taddr;
  assign analog_supply_source_sel = st_r.sleep[PRSC_SUPPLY_BIT];
  assign sleep_active             = st_r.asleep;
  assign digital_regulator_on     = st_r.digital_regulator;
  assign serial_format            = st_r.sfmt;

  // ==========================================================
  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_sync_n);

  a_page_write: assert property (
    reg_wr_en && reg_addr == PRSC_OFF_PAGE && !st_r.restart
    |=> page_sel == $past(reg_wdata))
    else $error("page not written");
  a_restart_dflt: assert property (
    st_r.restart |=> st_r.shdn == PRSC_RST_SHDN && st_r.sleep == 8'h00)
    else $error("restart left non-default value");
  a_restart_clr: assert property (
    st_r.restart |=> !st_r.restart)
    else $error("restart bit did not clear");
  a_bcast_addr: assert property (
    st_r.sleep[PRSC_BCAST_BIT] |=> target_addr == PRSC_BCAST_ADDR)
    else $error("broadcast address wrong");
  a_pin_addr: assert property (
    !st_r.sleep[PRSC_BCAST_BIT]
    |=> target_addr == {PRSC_ADDR_BASE, $past(st_r.apin_s[3:2])})
    else $error("pin address wrong");
  a_pol_now: assert property (
    shut_fall && policy == PRSC_POL_NOW |=> !digital_regulator_on)
    else $error("regulator not dropped");
  a_pol_time: assert property (
    shut_fall && policy == PRSC_POL_TIME && !shutdown_done
    |=> digital_regulator_on ##1 ka_busy)
    else $error("keepalive not started");
  a_pol_done: assert property (
    !st_r.pin_s[1] && policy == PRSC_POL_DONE && shutdown_done
    |=> !digital_regulator_on)
    else $error("regulator kept after finish");
  a_supply_sel: assert property (
    reg_wr_en && reg_addr == PRSC_OFF_SLEEP && page0 && !st_r.restart
    |=> analog_supply_source_sel == $past(reg_wdata[PRSC_SUPPLY_BIT]))
    else $error("supply select mismatch");
  a_wake_charge: assert property (
    wake && ref_ticks != 8'h00 |=> ref_charge_busy && incap_charge_busy)
    else $error("charge not started on wake");
  a_restart_read: assert property (
    reg_rd_en && reg_addr == PRSC_OFF_RST && !st_r.restart
    |=> reg_rdata == 8'h00)
    else $error("restart bit read as one");
endmodule

// ==== rtl/prsc_pkg.sv ====
// Package: constants for the page, restart, sleep and shutdown control block
package prsc_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] PRSC_OFF_PAGE  = 8'h00;
  localparam logic [7:0] PRSC_OFF_RST   = 8'h01;
  localparam logic [7:0] PRSC_OFF_SLEEP = 8'h02;
  localparam logic [7:0] PRSC_OFF_SHDN  = 8'h05;
  localparam logic [7:0] PRSC_OFF_SFMT  = 8'h07;
  localparam logic [7:0] PRSC_PAGE_ZERO = 8'h00;
  // ==========================================================
  // Reset values
  localparam logic [7:0] PRSC_RST_PAGE  = 8'h00;
  localparam logic [7:0] PRSC_RST_SLEEP = 8'h00;
  localparam logic [7:0] PRSC_RST_SHDN  = 8'h05;
  localparam logic [7:0] PRSC_RST_SFMT  = 8'h30;
  // ==========================================================
  // Field positions and masks
  localparam int PRSC_RST_BIT     = 0;
  localparam int PRSC_SUPPLY_BIT  = 7;
  localparam int PRSC_REFQ_LSB    = 3;
  localparam int PRSC_BCAST_BIT   = 2;
  localparam int PRSC_EXIT_BIT    = 0;
  localparam int PRSC_INCAP_LSB   = 4;
  localparam int PRSC_POLICY_LSB  = 2;
  localparam int PRSC_KA_LSB      = 0;
  localparam logic [7:0] PRSC_SLEEP_WMASK = 8'hfd;
  localparam logic [7:0] PRSC_SHDN_WMASK  = 8'h3f;
  // ==========================================================
  // Bus addressing
  localparam logic [6:0] PRSC_BCAST_ADDR = 7'h4c;
  localparam logic [4:0] PRSC_ADDR_BASE  = 5'h13;
  // ==========================================================
  // Timing: one tick is 500 us, durations held in microseconds
  localparam int CLK_PERIOD_NS  = 50;
  localparam int TICK_US        = 500;
  localparam int TICK_CYC       = TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int REFQ0_US  = 3500;
  localparam int REFQ1_US  = 10000;
  localparam int REFQ2_US  = 50000;
  localparam int REFQ3_US  = 100000;
  localparam int INCAP0_US = 2500;
  localparam int INCAP1_US = 12500;
  localparam int INCAP2_US = 25000;
  localparam int INCAP3_US = 50000;
  localparam int KA0_US    = 30000;
  localparam int KA1_US    = 25000;
  localparam int KA2_US    = 10000;
  localparam int KA3_US    = 5000;
  // ==========================================================
  // Shutdown policy codes
  localparam logic [1:0] PRSC_POL_NOW  = 2'h0;
  localparam logic [1:0] PRSC_POL_TIME = 2'h1;
  localparam logic [1:0] PRSC_POL_DONE = 2'h2;
  // Duration in microseconds to ticks
  function automatic logic [7:0] prsc_ticks(input int t_us);
    prsc_ticks = 8'(t_us / TICK_US);
  endfunction
endpackage

// ==== rtl/prsc_timer.sv ====
// Module: tick-driven one-shot duration timer
`timescale 1ns/10ps
module prsc_timer
  import prsc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clr,
  input  wire logic       start,
  input  wire logic       tick,
  input  wire logic [7:0] ticks,
  output logic            busy
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       busy;
  } prsc_tmr_s;
  prsc_tmr_s st_r;
  prsc_tmr_s st_nxt;

  // ==========================================================
  // Countdown: clear beats start, start beats a running count
  always_comb begin
    st_nxt = st_r;
    if (clr) begin
      st_nxt = '0;
    end else if (start) begin
      st_nxt.cnt  = ticks;
      st_nxt.busy = (ticks != 8'h00);
    end else if (tick && st_r.busy) begin
      if (st_r.cnt == 8'h01) begin
        st_nxt.busy = 1'b0;
      end
      st_nxt.cnt = st_r.cnt - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy = st_r.busy;
endmodule
